// ### logic/lble_eval.sv
// Ladder bit-logic evaluator: program store, entry port, scanner and bit image.
// Assumes inputs are asynchronous pins and the terminal port is on CLK_SYS.
`timescale 1ns/1ps
module lble_eval #(
  parameter int unsigned DEPTH = 144
) (
  input  wire logic                          CLK_SYS,
  input  wire logic                          RESET_N,
  input  wire logic                          PROG_MODE,
  input  wire lble_pkg::lble_pgm_t           PGM,
  output logic [lble_pkg::ADDR_W-1:0]        PGM_NEXT_ADDR,
  output logic                               PGM_FULL,
  input  wire logic [lble_pkg::N_IN-1:0]     IN_PINS,
  output logic [lble_pkg::N_OUT-1:0]         OUT_PINS,
  output logic                               RUNNING,
  output logic                               SCAN_DONE
);
  import lble_pkg::*;

  typedef enum {ST_IDLE, ST_CHECK, ST_EXEC} lble_st_t;

  logic [WORD_W-1:0] mem_q [DEPTH];
  logic [ADDR_W-1:0] wa_q, wa_d;
  logic [ADDR_W-1:0] pc_q, pc_d;
  lble_st_t          st_q, st_d;
  logic              cond_q, cond_d;
  logic [STACK_D-1:0] stk_q, stk_d;
  logic [N_OUT-1:0]  out_q, out_d;
  logic [N_WRK-1:0]  wrk_q, wrk_d;
  logic [N_IN-1:0]   in_s1_q, in_s2_q;
  logic              pm_s1_q, pm_s2_q;
  logic              done_q, done_d;
  logic [WORD_W-1:0] word;
  logic [3:0]        opc;
  logic [BIT_W-1:0]  bidx;
  logic              obit;

  function automatic logic [ADDR_W-1:0] entry_len(input logic [WORD_W-1:0] w);
    entry_len = ADDR_W'(w[LEN_HI:LEN_LO]) + 8'h01;
  endfunction

  function automatic logic bit_read(input logic [BIT_W-1:0] b, input logic [N_IN-1:0] i,
                                    input logic [N_OUT-1:0] o, input logic [N_WRK-1:0] k);
    logic [BIT_W-1:0] r;
    r = 8'h00;
    if (b < OUT_BASE) begin
      r = b - IN_BASE;
      bit_read = (r < BIT_W'(N_IN)) ? i[r[3:0]] : 1'b0;
    end else if (b < WRK_BASE) begin
      r = b - OUT_BASE;
      bit_read = (r < BIT_W'(N_OUT)) ? o[r[3:0]] : 1'b0;
    end else begin
      r = b - WRK_BASE;
      bit_read = (r < BIT_W'(N_WRK)) ? k[r[5:0]] : 1'b0;
    end
  endfunction

  // Synchronisers for input pins and the mode switch
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      in_s1_q <= '0;
      in_s2_q <= '0;
      pm_s1_q <= 1'b1;
      pm_s2_q <= 1'b1;
    end else begin
      in_s1_q <= IN_PINS;
      in_s2_q <= in_s1_q;
      pm_s1_q <= PROG_MODE;
      pm_s2_q <= pm_s1_q;
    end
  end

  // Program store written verbatim, no reset on the array
  always_ff @(posedge CLK_SYS) begin
    if (PGM.wr && pm_s2_q && wa_d < ADDR_W'(DEPTH)) begin
      mem_q[wa_d] <= PGM.data;
    end
  end

  // Entry address: auto advance, optional override
  always_comb begin
    wa_d = PGM.addr_set ? PGM.addr : wa_q;
    if (!pm_s2_q) begin
      wa_d = wa_q;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      wa_q <= '0;
    end else if (pm_s2_q && PGM.wr && wa_d < ADDR_W'(DEPTH)) begin
      wa_q <= wa_d + 8'h01;
    end else if (pm_s2_q && PGM.addr_set) begin
      wa_q <= PGM.addr;
    end
  end

  assign PGM_NEXT_ADDR = wa_q;
  assign PGM_FULL      = (wa_q >= ADDR_W'(DEPTH));

  // Current fetch word decode
  always_comb begin
    word = (pc_q < ADDR_W'(DEPTH)) ? mem_q[pc_q] : {OP_END, 12'h000};
    opc  = word[OPC_HI:OPC_LO];
    bidx = word[BIT_HI:BIT_LO];
    obit = bit_read(bidx, in_s2_q, out_q, wrk_q);
  end

  // Scanner next state
  always_comb begin
    st_d   = st_q;
    pc_d   = pc_q;
    cond_d = cond_q;
    stk_d  = stk_q;
    out_d  = out_q;
    wrk_d  = wrk_q;
    done_d = 1'b0;
    case (st_q)
      ST_IDLE: begin
        if (!pm_s2_q) begin
          st_d = ST_CHECK;
          pc_d = '0;
        end
      end
      ST_CHECK: begin // Look for an end marker before running
        if (pm_s2_q) begin
          st_d = ST_IDLE;
        end else if (opc == OP_END) begin
          st_d = ST_EXEC;
          pc_d = '0;
        end else if (pc_q + entry_len(word) >= ADDR_W'(DEPTH)) begin
          pc_d = '0;
        end else begin
          pc_d = pc_q + entry_len(word);
        end
      end
      ST_EXEC: begin
        pc_d = pc_q + entry_len(word);
        case (opc)
          OP_LOAD, OP_LOADN: begin
            stk_d  = {stk_q[STACK_D-2:0], cond_q};
            cond_d = (opc == OP_LOAD) ? obit : !obit;
          end
          OP_SER:  cond_d = cond_q & obit;
          OP_SERN: cond_d = cond_q & !obit;
          OP_PAR:  cond_d = cond_q | obit;
          OP_PARN: cond_d = cond_q | !obit;
          OP_CMBS, OP_CMBP: begin
            cond_d = (opc == OP_CMBS) ? (cond_q & stk_q[0]) : (cond_q | stk_q[0]);
            stk_d  = {1'b0, stk_q[STACK_D-1:1]};
          end
          OP_DRV, OP_DRVN: begin
            if (bidx >= OUT_BASE && bidx < OUT_BASE + BIT_W'(N_OUT)) begin
              out_d[4'(bidx - OUT_BASE)] = (opc == OP_DRV) ? cond_q : !cond_q;
            end else if (bidx >= WRK_BASE && bidx < WRK_BASE + BIT_W'(N_WRK)) begin
              wrk_d[6'(bidx - WRK_BASE)] = (opc == OP_DRV) ? cond_q : !cond_q;
            end
          end
          OP_END: begin
            pc_d   = '0;
            done_d = 1'b1;
          end
          default: ;
        endcase
        if (opc != OP_END && pc_q + entry_len(word) >= ADDR_W'(DEPTH)) begin
          pc_d = '0;
        end
        if (pm_s2_q) begin
          st_d  = ST_IDLE;
          out_d = out_q;
          wrk_d = wrk_q;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  // Scanner registers
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      st_q   <= ST_IDLE;
      pc_q   <= '0;
      cond_q <= 1'b0;
      stk_q  <= '0;
      out_q  <= '0;
      wrk_q  <= '0;
      done_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      pc_q   <= pc_d;
      cond_q <= cond_d;
      stk_q  <= stk_d;
      out_q  <= out_d;
      wrk_q  <= wrk_d;
      done_q <= done_d;
    end
  end

  assign OUT_PINS  = out_q;
  assign RUNNING   = (st_q == ST_EXEC);
  assign SCAN_DONE = done_q;

  property p_mode_stop;
    @(posedge CLK_SYS) disable iff (!RESET_N) pm_s2_q |=> !RUNNING;
  endproperty
  a_mode_stop: assert property (p_mode_stop) else $error("ran in programming mode");

  property p_out_hold;
    @(posedge CLK_SYS) disable iff (!RESET_N) pm_s2_q |=> $stable(OUT_PINS);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("outputs moved in programming mode");

  property p_load;
    @(posedge CLK_SYS) disable iff (!RESET_N) (RUNNING && !pm_s2_q && opc == OP_LOAD) |=> cond_q == $past(obit);
  endproperty
  a_load: assert property (p_load) else $error("load wrong");

  property p_ser;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      (RUNNING && !pm_s2_q && opc == OP_SERN) |=> cond_q == ($past(cond_q) & !$past(obit));
  endproperty
  a_ser: assert property (p_ser) else $error("series inverted wrong");

  property p_par;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      (RUNNING && !pm_s2_q && opc == OP_PAR) |=> cond_q == ($past(cond_q) | $past(obit));
  endproperty
  a_par: assert property (p_par) else $error("parallel wrong");

  property p_step;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      (RUNNING && opc != OP_END && pc_q + entry_len(word) < ADDR_W'(DEPTH)) |=> pc_q == $past(pc_q + entry_len(word));
  endproperty
  a_step: assert property (p_step) else $error("fetch step wrong");

  property p_end;
    @(posedge CLK_SYS) disable iff (!RESET_N) (RUNNING && opc == OP_END) |=> (pc_q == 8'h00 && SCAN_DONE);
  endproperty
  a_end: assert property (p_end) else $error("end did not restart");

  property p_drive;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      (RUNNING && !pm_s2_q && opc == OP_DRVN && bidx[7:4] == OUT_BASE[7:4])
      |=> OUT_PINS[$past(bidx[3:0])] == !$past(cond_q);
  endproperty
  a_drive: assert property (p_drive) else $error("drive inverted wrong");

  property p_auto;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      (pm_s2_q && PGM.wr && !PGM.addr_set && !PGM_FULL) |=> PGM_NEXT_ADDR == $past(PGM_NEXT_ADDR) + 8'h01;
  endproperty
  a_auto: assert property (p_auto) else $error("entry address not advanced");

  // Remaining bit operations against the operand bit
  property p_load_inv;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      (RUNNING && !pm_s2_q && opc == OP_LOADN) |=> cond_q == !$past(obit);
  endproperty
  a_load_inv: assert property (p_load_inv) else $error("load inverted wrong");

  property p_ser_plain;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      (RUNNING && !pm_s2_q && opc == OP_SER) |=> cond_q == ($past(cond_q) & $past(obit));
  endproperty
  a_ser_plain: assert property (p_ser_plain) else $error("series wrong");

  property p_par_inv;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      (RUNNING && !pm_s2_q && opc == OP_PARN) |=> cond_q == ($past(cond_q) | !$past(obit));
  endproperty
  a_par_inv: assert property (p_par_inv) else $error("parallel inverted wrong");

  property p_drive_plain;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      (RUNNING && !pm_s2_q && opc == OP_DRV && bidx[7:4] == OUT_BASE[7:4])
      |=> OUT_PINS[$past(bidx[3:0])] == $past(cond_q);
  endproperty
  a_drive_plain: assert property (p_drive_plain) else $error("drive wrong");

  // Saving a block condition and combining it back
  property p_push;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      (RUNNING && !pm_s2_q && (opc == OP_LOAD || opc == OP_LOADN)) |=> stk_q[0] == $past(cond_q);
  endproperty
  a_push: assert property (p_push) else $error("condition not saved");

  property p_cmb_ser;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      (RUNNING && !pm_s2_q && opc == OP_CMBS) |=> cond_q == ($past(cond_q) & $past(stk_q[0]));
  endproperty
  a_cmb_ser: assert property (p_cmb_ser) else $error("block series combine wrong");

  property p_cmb_par;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      (RUNNING && !pm_s2_q && opc == OP_CMBP) |=> cond_q == ($past(cond_q) | $past(stk_q[0]));
  endproperty
  a_cmb_par: assert property (p_cmb_par) else $error("block parallel combine wrong");

  // Scan start: search for an end marker first, then run from address zero
  property p_start;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      (st_q == ST_IDLE && !pm_s2_q) |=> (st_q == ST_CHECK && pc_q == 8'h00);
  endproperty
  a_start: assert property (p_start) else $error("scan did not start at zero");

  property p_check_wait;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      (st_q == ST_CHECK && opc != OP_END) |=> !RUNNING;
  endproperty
  a_check_wait: assert property (p_check_wait) else $error("ran before an end marker");

  property p_check_go;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      (st_q == ST_CHECK && !pm_s2_q && opc == OP_END) |=> (RUNNING && pc_q == 8'h00);
  endproperty
  a_check_go: assert property (p_check_go) else $error("end marker found but no run");

  property p_wrap;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      ((RUNNING || st_q == ST_CHECK) && !pm_s2_q && opc != OP_END && pc_q + entry_len(word) >= ADDR_W'(DEPTH))
      |=> pc_q == 8'h00;
  endproperty
  a_wrap: assert property (p_wrap) else $error("fetch ran past the top");

  // Entry port: override, lock while running, verbatim storage
  property p_addr_set;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      (pm_s2_q && PGM.addr_set && !PGM.wr) |=> PGM_NEXT_ADDR == $past(PGM.addr);
  endproperty
  a_addr_set: assert property (p_addr_set) else $error("entry address not moved");

  property p_run_lock;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      !pm_s2_q |=> $stable(PGM_NEXT_ADDR);
  endproperty
  a_run_lock: assert property (p_run_lock) else $error("entry accepted while running");

  property p_store;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      (pm_s2_q && PGM.wr && !PGM.addr_set && !PGM_FULL) |=> mem_q[$past(PGM_NEXT_ADDR)] == $past(PGM.data);
  endproperty
  a_store: assert property (p_store) else $error("word not stored as entered");

  c_scan: cover property (@(posedge CLK_SYS) disable iff (!RESET_N) SCAN_DONE);
  c_cmb:  cover property (@(posedge CLK_SYS) disable iff (!RESET_N) RUNNING && opc == OP_CMBS);
  c_drv:  cover property (@(posedge CLK_SYS) disable iff (!RESET_N) RUNNING && opc == OP_DRV);
  c_wrap: cover property (@(posedge CLK_SYS) disable iff (!RESET_N)
    st_q == ST_CHECK && pc_q + entry_len(word) >= ADDR_W'(DEPTH));
  c_stop: cover property (@(posedge CLK_SYS) disable iff (!RESET_N) RUNNING && pm_s2_q);
endmodule

// ### logic/lble_pkg.sv
// Package for the ladder bit-logic evaluator: word layout, opcodes, bit map, sizes.
// Assumes one system clock and a terminal that writes program words one at a time.
// How it works
// - Program memory starts at address zero and holds at most 144 words.
// - One address holds one word; an instruction takes one to eight consecutive addresses.
// - First word carries opcode, definer and any lone bit operand.
// - Words after the first are operand words, skipped by this evaluator.
// - Program is stored exactly as entered, no compiled form.
// - Every logic block begins with a load that starts a fresh condition.
// - Load copies the operand bit; load inverted copies its inverse.
// - Series ANDs the condition with the operand bit.
// - Series inverted ANDs the condition with the inverted operand bit.
// - Parallel ORs the condition with the operand bit.
// - Parallel inverted ORs the condition with the inverted operand bit.
// - Load, series and parallel forms each take one word.
// - Entries run in address order; each result feeds the next.
// - Drive sets its operand bit equal to the condition; one word.
// - Drive inverted sets its operand bit to the inverted condition.
// - Bit addresses from 0000 are inputs, from 0100 are outputs.
// - Entry address advances automatically; the terminal may override it.
// - A scan runs to the first end marker; no end marker, no execution.
// - Mid-line load saves the condition; combine ANDs or ORs it back.
// - In programming mode the program does not run nor drive outputs.
package lble_pkg;
  localparam int unsigned PROG_WORDS = 144;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned WORD_W     = 16;
  localparam int unsigned STACK_D    = 8;
  localparam int unsigned BIT_W      = 8;
  // First word: [15:12] opcode, [11:9] extra words, [8] definer, [7:0] bit index
  localparam int unsigned OPC_HI = 15;
  localparam int unsigned OPC_LO = 12;
  localparam int unsigned LEN_HI = 11;
  localparam int unsigned LEN_LO = 9;
  localparam int unsigned BIT_HI = 7;
  localparam int unsigned BIT_LO = 0;
  // Bit index map: 0x00.. inputs, 0x40.. outputs, rest internal work bits
  localparam logic [BIT_W-1:0] IN_BASE  = 8'h00;
  localparam logic [BIT_W-1:0] OUT_BASE = 8'h40;
  localparam logic [BIT_W-1:0] WRK_BASE = 8'h80;
  localparam int unsigned N_IN  = 16;
  localparam int unsigned N_OUT = 16;
  localparam int unsigned N_WRK = 64;
  localparam logic [3:0] OP_NOP   = 4'h0;
  localparam logic [3:0] OP_LOAD  = 4'h1;
  localparam logic [3:0] OP_LOADN = 4'h2;
  localparam logic [3:0] OP_SER   = 4'h3;
  localparam logic [3:0] OP_SERN  = 4'h4;
  localparam logic [3:0] OP_PAR   = 4'h5;
  localparam logic [3:0] OP_PARN  = 4'h6;
  localparam logic [3:0] OP_DRV   = 4'h7;
  localparam logic [3:0] OP_DRVN  = 4'h8;
  localparam logic [3:0] OP_CMBS  = 4'h9;
  localparam logic [3:0] OP_CMBP  = 4'ha;
  localparam logic [3:0] OP_END   = 4'hf;
  typedef struct packed {
    logic              wr;
    logic              addr_set;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] data;
  } lble_pgm_t;
endpackage

// ### tb/lble_term_model.sv
// Terminal model: enters program words on the entry port, one per request.
// Assumes the evaluator takes a word at the edge where wr is high.
`timescale 1ns/1ps
module lble_term_model (
  input  wire logic          CLK_SYS,
  output lble_pkg::lble_pgm_t PGM
);
  import lble_pkg::*;
  initial PGM = '0;
  // One-cycle request; then address and data flip so no stale word lingers
  task automatic drive(input logic w, input logic s, input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d);
    @(posedge CLK_SYS);
    PGM <= '{wr: w, addr_set: s, addr: a, data: d};
    @(posedge CLK_SYS);
    PGM <= '{wr: 1'b0, addr_set: 1'b0, addr: ~a, data: ~d};
  endtask
  // Word at the address the device offers
  task automatic put(input logic [WORD_W-1:0] d);
    drive(1'b1, 1'b0, '0, d);
  endtask
  // Word at an address of our own choosing
  task automatic put_at(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d);
    drive(1'b1, 1'b1, a, d);
  endtask
  task automatic set_addr(input logic [ADDR_W-1:0] a);
    drive(1'b0, 1'b1, a, '0);
  endtask
endmodule

// ### tb/tb_ladder_bit_logic_evaluator.sv
// Testbench for the ladder bit-logic evaluator: entry, logic scan, mode, end marker.
// Assumes the terminal model owns the entry port and the bench owns the pins.
`timescale 1ns/1ps
module tb_ladder_bit_logic_evaluator;
  import lble_pkg::*;
  logic              clk_sys;
  logic              reset_n;
  logic              prog_mode;
  logic [N_IN-1:0]   in_pins;
  logic [N_OUT-1:0]  out_pins;
  logic [ADDR_W-1:0] nxt;
  logic              full;
  logic              running;
  logic              scan_done;
  lble_pgm_t         pgm;
  int                fail_count;
  int                compares;
  int                cycles = 0;
  lble_eval #(.DEPTH(PROG_WORDS)) dut (.CLK_SYS(clk_sys), .RESET_N(reset_n), .PROG_MODE(prog_mode),
    .PGM(pgm), .PGM_NEXT_ADDR(nxt), .PGM_FULL(full), .IN_PINS(in_pins), .OUT_PINS(out_pins),
    .RUNNING(running), .SCAN_DONE(scan_done));
  lble_term_model term (.CLK_SYS(clk_sys), .PGM(pgm));
  // Clock of 4 ns
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // Cut a hang short
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      summarize();
    end
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  function automatic logic [15:0] w(input logic [3:0] op, input logic [2:0] n, input logic [7:0] b);
    return {op, n, 1'b0, b};
  endfunction
  // Count scan-done pulses, bounded
  task automatic scans(input int n);
    int k;
    k = 0;
    while (n > 0 && k < 600) begin
      @(posedge clk_sys);
      #1;
      if (scan_done === 1'b1) n--;
      k++;
    end
    chk("scan_done count", 16'h0, 16'(n));
  endtask
  // Entry address steps by one and may be moved
  task automatic test_entry();
    chk("next addr reset", 16'h0, 16'(nxt));
    term.put(w(OP_NOP, 3'h0, 8'h00));
    #1;
    chk("next addr step", 16'h1, 16'(nxt));
    term.set_addr(8'h8f);
    term.put(w(OP_NOP, 3'h0, 8'h00));
    #1;
    chk("next addr top", 16'h0090, 16'(nxt));
    chk("full flag", 16'h1, 16'(full));
    term.set_addr(8'h00);
    #1;
    chk("next addr moved", 16'h0, 16'(nxt));
    $display("test_entry done");
  endtask
  // Every bit op, a three-word entry, combines, and code past the end marker
  task automatic test_logic();
    logic [15:0] prog [0:20];
    logic [15:0] pats [0:5];
    logic [15:0] e;
    logic [15:0] p;
    prog = '{w(1,0,0), w(3,0,1), w(7,0,8'h40), w(2,0,2), w(6,0,3), w(8,0,8'h41), w(1,0,4),
             w(4,0,5), w(1,0,6), w(5,0,7), w(9,0,0), w(7,0,8'h42), w(1,2,0), 16'h7045, 16'h7045,
             w(1,0,8), w(10,0,0), w(7,0,8'h43), w(15,0,0), w(2,0,8'h0f), w(7,0,8'h44)};
    pats = '{16'h0000, 16'hffff, 16'h00d3, 16'h01a5, 16'h803c, 16'h0090};
    foreach (prog[i]) term.put(prog[i]);
    prog_mode <= 1'b0;
    foreach (pats[i]) begin
      p = pats[i];
      in_pins <= p;
      scans(3);
      e = 16'h0;
      e[0] = p[0] & p[1];
      e[1] = p[2] & p[3];
      e[2] = p[4] & ~p[5] & (p[6] | p[7]);
      e[3] = p[0] | p[8];
      chk("running", 16'h1, 16'(running));
      chk("outputs", e, out_pins);
      chk("out series", 16'(e[0]), 16'(out_pins[0]));
      chk("out inverted", 16'(e[1]), 16'(out_pins[1]));
      chk("out block and", 16'(e[2]), 16'(out_pins[2]));
      chk("out block or", 16'(e[3]), 16'(out_pins[3]));
    end
    $display("test_logic done");
  endtask
  // Programming mode halts the scan; without an end marker nothing runs
  task automatic test_halt();
    int seen;
    prog_mode <= 1'b1;
    repeat (10) @(posedge clk_sys);
    in_pins <= 16'hffff;
    repeat (20) @(posedge clk_sys);
    #1;
    chk("running in prog", 16'h0, 16'(running));
    chk("outputs held", 16'h0004, out_pins);
    // Fill the rest of memory so the end search must wrap over known words
    term.set_addr(8'h15);
    repeat (123) term.put(w(OP_NOP, 3'h0, 8'h00));
    #1;
    chk("next addr filled", 16'h0090, 16'(nxt));
    term.put_at(8'h12, w(OP_NOP, 3'h0, 8'h00));
    prog_mode <= 1'b0;
    seen = 0;
    repeat (300) begin
      @(posedge clk_sys);
      #1;
      if (running === 1'b1 || scan_done === 1'b1) seen++;
    end
    chk("run without end", 16'h0, 16'(seen));
    chk("outputs no end", 16'h0004, out_pins);
    prog_mode <= 1'b1;
    repeat (10) @(posedge clk_sys);
    term.put_at(8'h12, w(OP_END, 3'h0, 8'h00));
    prog_mode <= 1'b0;
    scans(3);
    chk("outputs end back", 16'h000b, out_pins);
    $display("test_halt done");
  endtask
  initial begin
    fail_count = 0;
    compares = 0;
    reset_n = 1'b0;
    prog_mode = 1'b1;
    in_pins = '0;
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    test_entry();
    test_logic();
    test_halt();
    summarize();
  end
endmodule
